// file: fbdx_pkg.sv
// Shared constants and types of the fieldbus data exchange block
package fbdx_pkg;
   // ********************
   // Link word layout
   // ********************
   localparam int NUM_WORDS = 16;            // Words each way
   typedef logic [NUM_WORDS-1:0][15:0] fbdx_words_t;  // Sixteen 16-bit link words
   // ********************
   // Selection codes
   // ********************
   localparam logic [3:0] SEL_CMD    = 4'h0; // Command mode
   localparam logic [3:0] SEL_STATUS = 4'h1; // Status monitor
   localparam logic [3:0] SEL_POS    = 4'h2; // Current position monitor
   localparam logic [3:0] SEL_CNT    = 4'h3; // Counter monitor
   localparam logic [3:0] SEL_RESET  = 4'h0; // Selection after reset
   // ********************
   // Counter monitor sub-modes
   // ********************
   localparam logic [15:0] CNT_ARB = 16'h0000; // Arbitrary selection
   localparam logic [15:0] CNT_SEQ = 16'h0001; // Sequence-number mode
   // ********************
   // Command codes and error codes
   // ********************
   localparam logic [15:0] CMD_STATUS = 16'hB900; // Request status
   localparam logic [15:0] CMD_POS    = 16'hE300; // Request position
   localparam logic [15:0] ERR_NONE   = 16'h0000; // Normal
   localparam logic [15:0] ERR_BAD    = 16'h1000; // Command analysis error
   localparam logic [15:0] ERR_BUSY   = 16'h2000; // Cannot execute now
   // ********************
   // Word positions inside a reply
   // ********************
   localparam int W_CODE = 0;  // Echo of command code
   localparam int W_ARG  = 1;  // Echo of argument
   localparam int W_VAL  = 2;  // Value word
   localparam int W_ERR  = 3;  // Error code word
   localparam int W_AXIS = 4;  // First axis coordinate word
   // ********************
   // Timing
   // ********************
   localparam int CLK_PERIOD_NS = 4;   // 250 MHz clock
   localparam int ECHO_DELAY_MS = 10;  // Selection echo lag
   localparam int ECHO_CYCLES   = ECHO_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   // ********************
   // Station handshake states
   // ********************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_FINISH
   } fbdx_st_t;
endpackage

// file: fbdx_link_if.sv
// Link between fieldbus master and secondary station
`timescale 1ns/1ns
interface fbdx_link_if;
   fbdx_pkg::fbdx_words_t cmdWords;      // Outgoing command words
   logic                  cmdRequest;    // Command processing request
   logic [3:0]            modeSelectIn;  // Data selection code
   fbdx_pkg::fbdx_words_t replyWords;    // Incoming reply words
   logic                  procFinish;    // Processing finish flag
   logic                  cmdError;      // Command error flag
   logic [3:0]            modeSelectChk; // Echoed selection code

   // Master end
   modport master (
      output cmdWords,
      output cmdRequest,
      output modeSelectIn,
      input  replyWords,
      input  procFinish,
      input  cmdError,
      input  modeSelectChk
   );
   // Station end
   modport station (
      input  cmdWords,
      input  cmdRequest,
      input  modeSelectIn,
      output replyWords,
      output procFinish,
      output cmdError,
      output modeSelectChk
   );
endinterface

// file: fbdx_sel_echo.sv
// Delayed echo of the data selection code
`timescale 1ns/1ns
module fbdx_sel_echo #(
   parameter int DELAY = fbdx_pkg::ECHO_CYCLES
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Selection in and echo out
   input  wire logic [3:0] selIn,
   output logic      [3:0] selOut
);
   logic [3:0]  pend_r;  // Code being timed
   logic [31:0] cnt_r;   // Cycles the code has been stable
   wire         changed = (selIn != pend_r);      // Input moved
   wire         expired = (cnt_r >= 32'(DELAY - 1)); // Lag elapsed

   // Restart the lag on every change, copy when it elapses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pend_r <= fbdx_pkg::SEL_RESET;
         cnt_r  <= 32'h0000_0000;
         selOut <= fbdx_pkg::SEL_RESET;
      end else if (changed) begin
         pend_r <= selIn;
         cnt_r  <= 32'h0000_0000;
      end else if (!expired) begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end else begin
         selOut <= pend_r;
      end
   end
endmodule

// file: fbdx_station.sv
// Secondary station end: command handshake, monitor refresh, echo
`timescale 1ns/1ns
module fbdx_station #(
   parameter int ECHO_CYCLES = fbdx_pkg::ECHO_CYCLES
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Link to the master
   fbdx_link_if.station               link,
   // Controller data
   input  wire logic [15:0]           statusVal,
   input  wire logic [3:0][31:0]      axisPos,
   input  wire logic [31:0]           counterVal,
   input  wire logic [15:0]           seqNo,
   input  wire logic                  ctrlBusy,
   // Command seen by the controller
   output logic                       cmdValid,
   output fbdx_pkg::fbdx_words_t      cmdBuf
);
   // ********************
   // State
   // ********************
   fbdx_pkg::fbdx_st_t    st_r;       // Handshake state
   fbdx_pkg::fbdx_st_t    st_nxt;     // Next handshake state
   fbdx_pkg::fbdx_words_t reply_r;    // Send-reply buffer
   fbdx_pkg::fbdx_words_t reply_nxt;  // Next reply
   logic                  finish_r;   // Finish flag
   logic                  error_r;    // Error flag
   logic                  errPend_r;  // Result of last command failed
   logic                  errPend_nxt;
   logic                  req_r;      // Previous request level

   // ********************
   // Decoding
   // ********************
   wire cmdMode  = (link.modeSelectIn == fbdx_pkg::SEL_CMD);
   wire reqRise  = link.cmdRequest && !req_r;
   // Requests outside command mode or mid-command are ignored
   wire startCmd = cmdMode && reqRise && (st_r == fbdx_pkg::ST_IDLE);
   wire isStatus = (cmdBuf[fbdx_pkg::W_CODE] == fbdx_pkg::CMD_STATUS);
   wire isPos    = (cmdBuf[fbdx_pkg::W_CODE] == fbdx_pkg::CMD_POS);
   wire known    = isStatus || isPos;
   wire [15:0] errCode = !known   ? fbdx_pkg::ERR_BAD :
                         ctrlBusy ? fbdx_pkg::ERR_BUSY :
                                    fbdx_pkg::ERR_NONE;
   wire cntSeq   = (link.cmdWords[0] == fbdx_pkg::CNT_SEQ);
   wire cntArb   = (link.cmdWords[0] == fbdx_pkg::CNT_ARB);

   // Place four 32-bit axis coordinates into eight reply words
   function automatic fbdx_pkg::fbdx_words_t putAxes(
      input fbdx_pkg::fbdx_words_t w,
      input logic [3:0][31:0]      pos
   );
      fbdx_pkg::fbdx_words_t r;
      r = w;
      for (int i = 0; i < 4; i++) begin
         r[fbdx_pkg::W_AXIS + 2*i]     = pos[i][15:0];
         r[fbdx_pkg::W_AXIS + 2*i + 1] = pos[i][31:16];
      end
      return r;
   endfunction

   // ********************
   // Next reply and handshake
   // ********************
   // Monitor modes rebuild the reply each cycle, command mode on execute
   always_comb begin
      reply_nxt   = reply_r;
      st_nxt      = st_r;
      errPend_nxt = errPend_r;
      unique case (st_r)
         fbdx_pkg::ST_IDLE: begin
            if (startCmd) begin
               st_nxt = fbdx_pkg::ST_EXEC;
            end
         end
         fbdx_pkg::ST_EXEC: begin
            // Build the reply from the receive buffer
            reply_nxt = '0;
            reply_nxt[fbdx_pkg::W_CODE] = cmdBuf[fbdx_pkg::W_CODE];
            reply_nxt[fbdx_pkg::W_ERR]  = errCode;
            if (errCode == fbdx_pkg::ERR_NONE && isStatus) begin
               reply_nxt[fbdx_pkg::W_ARG] = cmdBuf[fbdx_pkg::W_ARG];
               reply_nxt[fbdx_pkg::W_VAL] = statusVal;
            end else if (errCode == fbdx_pkg::ERR_NONE) begin
               reply_nxt = putAxes(reply_nxt, axisPos);
            end
            errPend_nxt = (errCode != fbdx_pkg::ERR_NONE);
            st_nxt      = fbdx_pkg::ST_FINISH;
         end
         fbdx_pkg::ST_FINISH: begin
            // Flags stand until the master drops its request
            if (!link.cmdRequest) begin
               st_nxt = fbdx_pkg::ST_IDLE;
            end
         end
      endcase
      // Continuous monitor refresh, no handshake
      if (!cmdMode) begin
         reply_nxt = '0;
         reply_nxt[fbdx_pkg::W_CODE] = link.cmdWords[0];
         unique case (link.modeSelectIn)
            fbdx_pkg::SEL_STATUS: begin
               reply_nxt[fbdx_pkg::W_VAL] = statusVal;
            end
            fbdx_pkg::SEL_POS: begin
               reply_nxt = putAxes(reply_nxt, axisPos);
            end
            fbdx_pkg::SEL_CNT: begin
               // Sub-mode chooses what word one holds; the same counter value is shown in every sub-mode
               if (cntSeq) begin
                  reply_nxt[fbdx_pkg::W_ARG] = seqNo;
               end else if (cntArb) begin
                  reply_nxt[fbdx_pkg::W_ARG] = link.cmdWords[1];
               end else begin
                  reply_nxt[fbdx_pkg::W_ERR] = fbdx_pkg::ERR_BAD;
               end
               reply_nxt[fbdx_pkg::W_VAL]     = counterVal[15:0];
               reply_nxt[fbdx_pkg::W_VAL + 2] = counterVal[31:16];
            end
            default: begin
               reply_nxt = '0; // Reserved codes give zeros
            end
         endcase
         st_nxt = fbdx_pkg::ST_IDLE;
      end
   end

   // ********************
   // Registers
   // ********************
   // Handshake state and flags
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r      <= fbdx_pkg::ST_IDLE;
         errPend_r <= 1'b0;
         req_r     <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         errPend_r <= errPend_nxt;
         req_r     <= link.cmdRequest;
      end
   end

   // Receive buffer latched at the request edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmdBuf   <= '0;
         cmdValid <= 1'b0;
      end else begin
         cmdValid <= startCmd;
         if (startCmd) begin
            cmdBuf <= link.cmdWords;
         end
      end
   end

   // Reply words then finish one cycle later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reply_r  <= '0;
         finish_r <= 1'b0;
         error_r  <= 1'b0;
      end else begin
         reply_r <= reply_nxt;
         if (st_r == fbdx_pkg::ST_FINISH && link.cmdRequest) begin
            finish_r <= 1'b1;
            error_r  <= errPend_r;
         end else begin
            finish_r <= 1'b0;
            error_r  <= 1'b0;
         end
      end
   end

   // Link outputs come straight from the reply and flag registers
   assign link.replyWords = reply_r;
   assign link.procFinish = finish_r;
   assign link.cmdError   = error_r;

   // ********************
   // Selection echo
   // ********************
   // Echo lag restarts whenever the selection moves
   fbdx_sel_echo #(
      .DELAY (ECHO_CYCLES)
   ) u_fbdx_sel_echo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .selIn   (link.modeSelectIn),
      .selOut  (link.modeSelectChk)
   );
endmodule

// file: fbdx_master.sv
// Fieldbus master end: selection, command issue and reply capture
`timescale 1ns/1ns
module fbdx_master (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Link to the station
   fbdx_link_if.master                link,
   // User requests
   input  wire logic [3:0]            modeReq,
   input  wire logic                  cmdStart,
   input  wire fbdx_pkg::fbdx_words_t cmdIn,
   // User results
   output logic                       cmdBusy,
   output logic                       cmdDone,
   output logic                       cmdFailed,
   output logic                       modeReady,
   output fbdx_pkg::fbdx_words_t      replyOut
);
   typedef enum logic [1:0] {
      M_IDLE,
      M_WRITE,
      M_REQ,
      M_CLEAR
   } fbdx_mst_t;

   fbdx_mst_t             st_r;      // Master state
   fbdx_pkg::fbdx_words_t words_r;   // Outgoing words
   logic                  req_r;     // Request level
   logic [3:0]            mode_r;    // Selection driven out

   // Handshakes quiet and echo matches command mode
   wire quiet  = !link.cmdRequest && !link.procFinish && !link.cmdError;
   wire echoOk = (link.modeSelectChk == mode_r);
   wire canGo  = quiet && echoOk && (mode_r == fbdx_pkg::SEL_CMD);

   // Command sequence
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r      <= M_IDLE;
         words_r   <= '0;
         req_r     <= 1'b0;
         mode_r    <= fbdx_pkg::SEL_RESET;
         cmdBusy   <= 1'b0;
         cmdDone   <= 1'b0;
         cmdFailed <= 1'b0;
         modeReady <= 1'b0;
         replyOut  <= '0;
      end else begin
         cmdDone   <= 1'b0;
         modeReady <= echoOk && (modeReq == mode_r);
         unique case (st_r)
            M_IDLE: begin
               // Selection frozen on the edge a command starts
               if (!(cmdStart && canGo)) begin
                  mode_r <= modeReq;
               end
               if (cmdStart && canGo) begin
                  words_r <= cmdIn;
                  cmdBusy <= 1'b1;
                  st_r    <= M_WRITE;
               end
            end
            M_WRITE: begin
               req_r <= 1'b1;
               st_r  <= M_REQ;
            end
            M_REQ: begin
               // Capture reply and error, then drop request
               if (link.procFinish) begin
                  replyOut  <= link.replyWords;
                  cmdFailed <= link.cmdError;
                  req_r     <= 1'b0;
                  st_r      <= M_CLEAR;
               end
            end
            M_CLEAR: begin
               if (!link.procFinish) begin
                  cmdDone <= 1'b1;
                  cmdBusy <= 1'b0;
                  st_r    <= M_IDLE;
               end
            end
         endcase
      end
   end

   assign link.cmdWords     = words_r;
   assign link.cmdRequest   = req_r;
   assign link.modeSelectIn = mode_r;
endmodule

// file: fbdx_link_chk.sv
// Checker watching the link between master end and station end
`timescale 1ns/1ns
module fbdx_link_chk #(
   parameter int ECHO_CYCLES = fbdx_pkg::ECHO_CYCLES
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // Link signals
   input wire fbdx_pkg::fbdx_words_t cmdWords,
   input wire logic                  cmdRequest,
   input wire logic [3:0]            modeSelectIn,
   input wire fbdx_pkg::fbdx_words_t replyWords,
   input wire logic                  procFinish,
   input wire logic                  cmdError,
   input wire logic [3:0]            modeSelectChk
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ********************
   // Selection stability counter
   // ********************
   logic [3:0] prevSel_r;                                  // Selection one cycle ago
   logic [7:0] stabCnt_r;                                  // Cycles selection held still
   wire        selMoved = (modeSelectIn != prevSel_r);     // Selection changed
   wire        monSel   = (modeSelectIn != 4'h0) && (modeSelectIn <= fbdx_pkg::SEL_CNT);
   // Count unchanged cycles, saturating
   always_ff @(posedge clk) begin
      prevSel_r <= sys_rst ? 4'h0 : modeSelectIn;
      if (sys_rst || selMoved) begin
         stabCnt_r <= 8'h00;
      end else if (stabCnt_r != 8'hFF) begin
         stabCnt_r <= stabCnt_r + 8'h01;
      end
   end
   // ********************
   // Handshake
   // ********************
   a_err_with_fin: assert property (cmdError |-> procFinish)
      else $error("error flag without finish");
   a_fin_latency: assert property (
      $rose(cmdRequest) && modeSelectIn == 4'h0 && !procFinish |-> ##3 procFinish)
      else $error("finish not three cycles after request");
   a_reply_first: assert property ($rose(procFinish) |-> $stable(replyWords))
      else $error("reply changed with finish");
   a_fin_holds: assert property (
      procFinish && cmdRequest |=> procFinish && $stable(cmdError))
      else $error("finish dropped while request high");
   a_flags_clear: assert property (procFinish && !cmdRequest |-> ##[1:2] !procFinish)
      else $error("finish stuck after request low");
   a_drop_together: assert property ($fell(cmdError) |-> $fell(procFinish))
      else $error("error flag dropped alone");
   // ********************
   // Monitor modes and echo
   // ********************
   a_mon_quiet: assert property (
      modeSelectIn != 4'h0 && $stable(modeSelectIn) |-> !procFinish)
      else $error("handshake in monitor mode");
   a_mon_refresh: assert property (
      monSel && $stable(modeSelectIn) |=> replyWords[0] == $past(cmdWords[0]))
      else $error("monitor word zero stale");
   a_cnt_arb: assert property (
      modeSelectIn == fbdx_pkg::SEL_CNT && cmdWords[0] == 16'h0000
      |=> replyWords[1] == $past(cmdWords[1]))
      else $error("counter arbitrary word wrong");
   a_reserved_zero: assert property (modeSelectIn > fbdx_pkg::SEL_CNT |=> replyWords == '0)
      else $error("reserved mode reply not zero");
   a_echo_copy: assert property (
      $changed(modeSelectChk) |-> modeSelectChk == $past(modeSelectIn))
      else $error("echo differs from selection");
   a_echo_settle: assert property (
      stabCnt_r == ECHO_CYCLES + 3 |-> modeSelectChk == modeSelectIn)
      else $error("echo late");
endmodule

// file: fbdx_bench.sv
// Bench joining master end and station end, checker beside the link
`timescale 1ns/1ns
module fbdx_bench;
   // ********************
   // Signals
   // ********************
   localparam int         ECHO = 8;   // Short echo lag
   logic                  clk;        // 250 MHz clock
   logic                  sys_rst;    // Synchronous reset
   logic [15:0]           statusVal;  // Controller status
   logic [3:0][31:0]      axisPos;    // Axis coordinates
   logic [31:0]           counterVal; // Counter value
   logic [15:0]           seqNo;      // Sequence number
   logic                  ctrlBusy;   // Controller busy
   logic [3:0]            modeReq;    // Requested selection
   logic                  cmdStart;   // Start command
   fbdx_pkg::fbdx_words_t cmdIn;      // Command words
   logic                  cmdValid;   // Station command pulse
   fbdx_pkg::fbdx_words_t cmdBuf;     // Station receive buffer
   logic                  cmdBusy;    // Master busy
   logic                  cmdDone;    // Master done pulse
   logic                  cmdFailed;  // Master error result
   logic                  modeReady;  // Master mode settled
   fbdx_pkg::fbdx_words_t replyOut;   // Captured reply
   int                    nFail;      // Mismatches
   int                    checksDone; // Comparisons
   fbdx_link_if link();               // Link under check
   fbdx_link_if linkB();              // Link driven by the bench
   // ********************
   // Instances
   // ********************
   fbdx_station #(.ECHO_CYCLES(ECHO)) u_fbdx_station (.clk, .sys_rst, .link(link), .statusVal,
      .axisPos, .counterVal, .seqNo, .ctrlBusy, .cmdValid, .cmdBuf);
   fbdx_station #(.ECHO_CYCLES(ECHO)) u_fbdx_station_b (.clk, .sys_rst, .link(linkB), .statusVal,
      .axisPos, .counterVal, .seqNo, .ctrlBusy, .cmdValid(), .cmdBuf());
   fbdx_master u_fbdx_master (.clk, .sys_rst, .link(link), .modeReq, .cmdStart, .cmdIn,
      .cmdBusy, .cmdDone, .cmdFailed, .modeReady, .replyOut);
   fbdx_link_chk #(.ECHO_CYCLES(ECHO)) u_fbdx_link_chk (.clk, .sys_rst,
      .cmdWords(link.cmdWords), .cmdRequest(link.cmdRequest), .modeSelectIn(link.modeSelectIn),
      .replyWords(link.replyWords), .procFinish(link.procFinish), .cmdError(link.cmdError),
      .modeSelectChk(link.modeSelectChk));
   // ********************
   // Shared tasks
   // ********************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic runCmd(input logic [15:0] code, input logic [15:0] arg, input logic [15:0] err);
      int i;
      cmdIn = '0;
      cmdIn[0] = code;
      cmdIn[1] = arg;
      cmdStart = 1'b1;
      for (i = 0; i < 100 && cmdBusy !== 1'b1; i++) tick(1);
      cmdStart = 1'b0;
      for (i = 0; i < 100 && cmdValid !== 1'b1; i++) tick(1);
      chk("command pulse", 16'h0001, {15'h0, cmdValid});
      chk("command word", code, cmdBuf[0]);
      for (i = 0; i < 100 && cmdDone !== 1'b1; i++) tick(1);
      chk("done pulse", 16'h0001, {15'h0, cmdDone});
      chk("busy cleared", 16'h0000, {15'h0, cmdBusy});
      chk("reply code", code, replyOut[0]);
      chk("error word", err, replyOut[3]);
      chk("failed flag", {15'h0, err != 16'h0}, {15'h0, cmdFailed});
      chk("receive buffer", arg, cmdBuf[1]);
   endtask
   task automatic setMode(input logic [3:0] m);
      int i;
      logic [3:0] prevChk;
      prevChk = link.modeSelectChk;
      modeReq = m;
      tick(2);
      chk("echo lag", {12'h0, prevChk}, {12'h0, link.modeSelectChk});
      for (i = 0; i < 100 && (modeReady !== 1'b1 || link.modeSelectChk !== m); i++)
         tick(1);
      chk("selection echo", {12'h0, m}, {12'h0, link.modeSelectChk});
      chk("mode ready", 16'h0001, {15'h0, modeReady});
      tick(2);
   endtask
   // ********************
   // Scenarios
   // ********************
   task automatic tCommands;
      runCmd(fbdx_pkg::CMD_STATUS, 16'h0005, fbdx_pkg::ERR_NONE);
      chk("status value", statusVal, replyOut[2]);
      chk("status number", 16'h0005, replyOut[1]);
      runCmd(fbdx_pkg::CMD_POS, 16'h0000, fbdx_pkg::ERR_NONE);
      for (int a = 0; a < 4; a++) begin
         chk("axis low", axisPos[a][15:0], replyOut[4 + 2 * a]);
         chk("axis high", axisPos[a][31:16], replyOut[5 + 2 * a]);
      end
      ctrlBusy = 1'b1;
      runCmd(fbdx_pkg::CMD_STATUS, 16'h0001, fbdx_pkg::ERR_BUSY);
      ctrlBusy = 1'b0;
      runCmd(16'h1234, 16'h0002, fbdx_pkg::ERR_BAD);
      $display("test commands done");
   endtask
   task automatic tCounter(input logic [15:0] sub, input logic [15:0] w1, input logic [15:0] err);
      runCmd(sub, 16'h00A5, fbdx_pkg::ERR_BAD);
      setMode(fbdx_pkg::SEL_CNT);
      chk("counter sub word", w1, link.replyWords[1]);
      chk("counter sub error", err, link.replyWords[3]);
      chk("counter low", counterVal[15:0], link.replyWords[2]);
      chk("counter high", counterVal[31:16], link.replyWords[4]);
      setMode(fbdx_pkg::SEL_CMD);
      $display("test counter done");
   endtask
   task automatic tMonitors;
      setMode(fbdx_pkg::SEL_STATUS);
      chk("status monitor", statusVal, link.replyWords[2]);
      statusVal = 16'h1234;
      tick(2);
      chk("status refresh", 16'h1234, link.replyWords[2]);
      setMode(fbdx_pkg::SEL_POS);
      chk("position low", axisPos[0][15:0], link.replyWords[4]);
      chk("position high", axisPos[3][31:16], link.replyWords[11]);
      setMode(4'hF);
      chk("reserved reply", 16'h0, {15'h0, |link.replyWords});
      setMode(fbdx_pkg::SEL_CMD);
      $display("test monitors done");
   endtask
   task automatic tFault;
      linkB.cmdWords[0] = fbdx_pkg::CMD_STATUS;
      linkB.modeSelectIn = fbdx_pkg::SEL_STATUS;
      linkB.cmdRequest = 1'b1;
      tick(6);
      chk("finish in monitor", 16'h0, {15'h0, linkB.procFinish});
      linkB.modeSelectIn = fbdx_pkg::SEL_CMD;
      tick(6);
      chk("finish without edge", 16'h0, {15'h0, linkB.procFinish});
      linkB.cmdRequest = 1'b0;
      tick(1);
      linkB.cmdRequest = 1'b1;
      tick(4);
      chk("finish on edge", 16'h1, {15'h0, linkB.procFinish});
      chk("no error on edge", 16'h0, {15'h0, linkB.cmdError});
      chk("fault status word", statusVal, linkB.replyWords[2]);
      linkB.cmdRequest = 1'b0;
      tick(2);
      chk("finish cleared", 16'h0, {15'h0, linkB.procFinish});
      $display("test fault done");
   endtask
   // ********************
   // Clock, watchdog and main sequence
   // ********************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Cut a hang short
   initial begin
      repeat (5000) @(posedge clk);
      nFail++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      wrapUp();
   end
   // Reset, then scenarios
   initial begin
      sys_rst = 1'b1;
      statusVal = 16'h5A3C;
      axisPos = {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
      counterVal = 32'hC0DE_0042;
      seqNo = 16'h0077;
      ctrlBusy = 1'b0;
      modeReq = 4'h0;
      cmdStart = 1'b0;
      cmdIn = '0;
      nFail = 0;
      checksDone = 0;
      linkB.cmdWords = '0;
      linkB.cmdRequest = 1'b0;
      linkB.modeSelectIn = 4'h0;
      tick(6);
      sys_rst = 1'b0;
      tCommands();
      tCounter(fbdx_pkg::CNT_ARB, 16'h00A5, fbdx_pkg::ERR_NONE);
      tCounter(fbdx_pkg::CNT_SEQ, seqNo, fbdx_pkg::ERR_NONE);
      tCounter(16'h0002, 16'h0000, fbdx_pkg::ERR_BAD);
      tMonitors();
      tFault();
      wrapUp();
   end
endmodule
